// file: rtl/aih_pkg.sv
// package for the area information request handler: packet bytes, status codes,
// descriptor layout, receive/reply states and the default area table.
// assumes a byte stream from a receiver and a byte sink on the same clock.
package aih_pkg;

    // framing bytes
    localparam logic [7:0]  BYTE_START     = 8'h01;
    localparam logic [7:0]  BYTE_END       = 8'h03;
    localparam logic [7:0]  CMD_AREA_INFO  = 8'h3b;
    localparam logic [7:0]  REPLY_START    = 8'h81;
    localparam logic [7:0]  REPLY_ERR_CODE = 8'hbb;
    localparam logic [7:0]  LEN_HIGH       = 8'h00;
    localparam logic [15:0] LEN_REQ        = 16'h0002;
    localparam logic [7:0]  LEN_LOW_OK     = 8'h1a;
    localparam logic [7:0]  LEN_LOW_ERR    = 8'h0a;
    localparam logic [31:0] UNUSED_WORD    = 32'hffffffff;

    // largest body length accepted by the generic packet format
    localparam logic [15:0] PKT_LEN_MAX    = 16'h0400;

    // status codes (values are arbitrary)
    localparam logic [7:0]  STS_OK         = 8'h00;
    localparam logic [7:0]  STS_PACKET     = 8'hc1;
    localparam logic [7:0]  STS_CHECKSUM   = 8'hc2;
    localparam logic [7:0]  STS_ACCEPT     = 8'hc3;
    localparam logic [7:0]  STS_PARAM      = 8'hc4;

    // area_kind categories, upper nibble
    localparam logic [3:0]  KIND_USER      = 4'h0;
    localparam logic [3:0]  KIND_DATA      = 4'h1;
    localparam logic [3:0]  KIND_CONFIG    = 4'h2;
    localparam logic [3:0]  KIND_EEP_CFG   = 4'h3;
    localparam logic [3:0]  KIND_EXT_FLASH = 4'h4;

    // reply byte positions
    localparam logic [4:0]  OK_LAST_IDX    = 5'h1e;
    localparam logic [4:0]  ERR_LAST_IDX   = 5'h0e;
    localparam logic [4:0]  PAYLOAD_IDX    = 5'h04;

    // one byte of a stream
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } aih_byte_t;

    // area descriptor, fields in send order, most significant first
    typedef struct packed {
        logic [7:0]  area_kind;
        logic [31:0] start_address;
        logic [31:0] end_address;
        logic [31:0] erase_unit;
        logic [31:0] write_unit;
        logic [31:0] read_unit;
        logic [31:0] crc_unit;
    } aih_desc_t;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_LEN_HI = 3'b001,
        ST_LEN_LO = 3'b010,
        ST_BODY   = 3'b011,
        ST_SUM    = 3'b100,
        ST_END    = 3'b101,
        ST_CHECK  = 3'b110,
        ST_SEND   = 3'b111
    } aih_state_t;

    localparam int AREA_COUNT = 4;

    localparam aih_desc_t [AREA_COUNT-1:0] AREA_TABLE = '{
        '{8'h40, 32'h60000000, 32'h9fffffff, 32'h00000001, 32'h00000001,
          32'h00000001, 32'h00000400},
        '{8'h10, 32'h27000000, 32'h27002fff, 32'h00000040, 32'h00000004,
          32'h00000001, 32'h00000400},
        '{8'h20, 32'h0300a100, 32'h0300a17f, 32'h00000000, 32'h00000010,
          32'h00000001, 32'h00000080},
        '{8'h00, 32'h02000000, 32'h0200ffff, 32'h00002000, 32'h00000080,
          32'h00000001, 32'h00008000}
    };

endpackage : aih_pkg

// file: rtl/aih_area_rom.sv
// area descriptor table with registered read data.
// assumes the address is held stable while the data are used.
`timescale 1ns/10ps
module aih_area_rom #(
    parameter int                                N     = aih_pkg::AREA_COUNT,
    parameter aih_pkg::aih_desc_t [N-1:0]        TABLE = aih_pkg::AREA_TABLE
) (
    input  wire logic               i_clk_sys,
    input  wire logic               i_rst,
    input  wire logic [7:0]         i_addr,
    output aih_pkg::aih_desc_t      o_data
);
    localparam int AW = (N > 1) ? $clog2(N) : 1;

    // entries past the table read as zero
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_data <= '0;
        end else if (i_addr < 8'(N)) begin
            o_data <= TABLE[i_addr[AW-1:0]];
        end else begin
            o_data <= '0;
        end
    end

endmodule : aih_area_rom

// file: rtl/aih_handler.sv
// area information request handler: parses a framed request, checks it and
// answers with a descriptor or an error status packet.
// assumes byte streams from and to a serial transport on the same clock.
//
// Behaviour
// - request: 01,00,02,3B,index,check,03
// - good reply: 81,00,1A,3B,descriptor,check,03
// - area_kind: category nibble high, instance low
// - start and end address, four bytes, MSB first
// - erase_unit four bytes, MSB first
// - write_unit four bytes, MSB first
// - read_unit four bytes, MSB first
// - crc_unit four bytes, MSB first
// - zero unit means command unsupported there
// - error reply: 81,00,0A,BB,status,detail,location,check,03
// - idle discards bytes until start byte
// - missing end byte gives packet error
// - bad frame check gives checksum error
// - bad nonzero length gives packet error, zero length gets no reply
// - encrypted write since reset: acceptance error
// - index at or above count: parameter error
// - errors change nothing, back to waiting
// - highest error wins, detail/location all ones
// - success sends descriptor then waits again
// - rate command untouched, no rate change here
// - area_count bounds the index, reported
`timescale 1ns/10ps
module aih_handler #(
    parameter int                               AREA_COUNT = aih_pkg::AREA_COUNT,
    parameter aih_pkg::aih_desc_t [AREA_COUNT-1:0] AREA_TABLE = aih_pkg::AREA_TABLE
) (
    input  wire logic               i_clk_sys,
    input  wire logic               i_rst,
    input  wire aih_pkg::aih_byte_t i_rx,
    output logic                    o_rx_ready,
    output aih_pkg::aih_byte_t      o_tx,
    input  wire logic               i_tx_ready,
    input  wire logic               i_enc_write_done,
    output logic [7:0]              o_area_count,
    output logic [7:0]              o_last_status,
    output logic                    o_reply_done
);

    aih_pkg::aih_state_t state_reg;
    aih_pkg::aih_state_t state_next;

    logic [15:0]               len_reg;
    logic [15:0]               cnt_reg;
    logic [7:0]                rx_sum_reg;
    logic [7:0]                cmd_reg;
    logic [7:0]                index_reg;
    logic                      etx_ok_reg;
    logic                      enc_seen_reg;
    logic [199:0]              payload_reg;
    logic [7:0]                status_reg;
    logic [4:0]                tx_idx_reg;
    logic [7:0]                tx_sum_reg;
    aih_pkg::aih_desc_t        rom_data;
    logic                      rx_take;
    logic                      ours;
    logic [7:0]                status_calc;
    logic [7:0]                tx_byte;
    logic [4:0]                last_idx;
    logic                      push;
    logic                      buf_in_ready_reg;
    aih_pkg::aih_byte_t        spare_reg;

    // most significant byte first from a word
    function automatic logic [7:0] word_byte(input logic [199:0] w, input logic [4:0] k);
        logic [7:0] pos;
        pos = 8'(199 - 8 * int'(k));
        word_byte = w[pos -: 8];
    endfunction : word_byte

    assign rx_take = i_rx.valid && o_rx_ready;
    assign ours    = (cmd_reg == aih_pkg::CMD_AREA_INFO) && (len_reg != 16'h0000);
    assign push    = (state_reg == aih_pkg::ST_SEND) && buf_in_ready_reg;
    assign last_idx = (status_reg == aih_pkg::STS_OK) ? aih_pkg::OK_LAST_IDX
                                                      : aih_pkg::ERR_LAST_IDX;

    aih_area_rom #(
        .N     (AREA_COUNT),
        .TABLE (AREA_TABLE)
    ) u_rom (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_addr    (index_reg),
        .o_data    (rom_data)
    );

    // error ranking, first match wins
    always_comb begin
        if (!etx_ok_reg) begin
            status_calc = aih_pkg::STS_PACKET;
        end else if (rx_sum_reg != 8'h00) begin
            status_calc = aih_pkg::STS_CHECKSUM;
        end else if (len_reg > aih_pkg::PKT_LEN_MAX) begin
            status_calc = aih_pkg::STS_PACKET;
        end else if (len_reg != aih_pkg::LEN_REQ) begin
            status_calc = aih_pkg::STS_PACKET;
        end else if (enc_seen_reg) begin
            status_calc = aih_pkg::STS_ACCEPT;
        end else if (index_reg >= 8'(AREA_COUNT)) begin
            status_calc = aih_pkg::STS_PARAM;
        end else begin
            status_calc = aih_pkg::STS_OK;
        end
    end

    // receive and reply sequencing
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            aih_pkg::ST_IDLE: begin
                if (rx_take && i_rx.data == aih_pkg::BYTE_START) begin
                    state_next = aih_pkg::ST_LEN_HI;
                end
            end
            aih_pkg::ST_LEN_HI: begin
                if (rx_take) begin
                    state_next = aih_pkg::ST_LEN_LO;
                end
            end
            aih_pkg::ST_LEN_LO: begin
                if (rx_take) begin
                    if ({len_reg[15:8], i_rx.data} == 16'h0000) begin
                        state_next = aih_pkg::ST_SUM;
                    end else begin
                        state_next = aih_pkg::ST_BODY;
                    end
                end
            end
            aih_pkg::ST_BODY: begin
                if (rx_take && cnt_reg == len_reg - 16'h0001) begin
                    state_next = aih_pkg::ST_SUM;
                end
            end
            aih_pkg::ST_SUM: begin
                if (rx_take) begin
                    state_next = aih_pkg::ST_END;
                end
            end
            aih_pkg::ST_END: begin
                if (rx_take) begin
                    state_next = aih_pkg::ST_CHECK;
                end
            end
            aih_pkg::ST_CHECK: begin
                // other commands, the rate command among them, belong elsewhere
                if (ours) begin
                    state_next = aih_pkg::ST_SEND;
                end else begin
                    state_next = aih_pkg::ST_IDLE;
                end
            end
            aih_pkg::ST_SEND: begin
                if (push && tx_idx_reg == last_idx) begin
                    state_next = aih_pkg::ST_IDLE;
                end
            end
            default: begin
                state_next = aih_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            state_reg <= aih_pkg::ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // ready in every state except while a request is checked or answered
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_rx_ready <= 1'b0;
        end else begin
            o_rx_ready <= (state_next != aih_pkg::ST_CHECK) &&
                          (state_next != aih_pkg::ST_SEND);
        end
    end

    // request capture and running sum
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            len_reg    <= 16'h0000;
            cnt_reg    <= 16'h0000;
            rx_sum_reg <= 8'h00;
            cmd_reg    <= 8'h00;
            index_reg  <= 8'h00;
            etx_ok_reg <= 1'b0;
        end else if (rx_take) begin
            case (state_reg)
                aih_pkg::ST_IDLE: begin
                    rx_sum_reg <= 8'h00;
                    cnt_reg    <= 16'h0000;
                    cmd_reg    <= 8'h00;
                    index_reg  <= 8'h00;
                end
                aih_pkg::ST_LEN_HI: begin
                    len_reg[15:8] <= i_rx.data;
                    rx_sum_reg    <= rx_sum_reg + i_rx.data;
                end
                aih_pkg::ST_LEN_LO: begin
                    len_reg[7:0] <= i_rx.data;
                    rx_sum_reg   <= rx_sum_reg + i_rx.data;
                end
                aih_pkg::ST_BODY: begin
                    if (cnt_reg == 16'h0000) begin
                        cmd_reg <= i_rx.data;
                    end
                    if (cnt_reg == 16'h0001) begin
                        index_reg <= i_rx.data;
                    end
                    cnt_reg    <= cnt_reg + 16'h0001;
                    rx_sum_reg <= rx_sum_reg + i_rx.data;
                end
                aih_pkg::ST_SUM: begin
                    rx_sum_reg <= rx_sum_reg + i_rx.data;
                end
                aih_pkg::ST_END: begin
                    etx_ok_reg <= (i_rx.data == aih_pkg::BYTE_END);
                end
                default: begin
                end
            endcase
        end
    end

    // encrypted write seen since reset, cleared only by reset
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            enc_seen_reg <= 1'b0;
        end else if (i_enc_write_done) begin
            enc_seen_reg <= 1'b1;
        end
    end

    // reply payload: descriptor or status with all-ones detail and location
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            payload_reg <= '0;
            status_reg  <= aih_pkg::STS_OK;
        end else if (state_reg == aih_pkg::ST_CHECK && ours) begin
            status_reg <= status_calc;
            if (status_calc == aih_pkg::STS_OK) begin
                payload_reg <= rom_data;
            end else begin
                payload_reg <= {status_calc, aih_pkg::UNUSED_WORD,
                                aih_pkg::UNUSED_WORD, 128'h0};
            end
        end
    end

    // reply byte selection
    always_comb begin
        if (tx_idx_reg == 5'h00) begin
            tx_byte = aih_pkg::REPLY_START;
        end else if (tx_idx_reg == 5'h01) begin
            tx_byte = aih_pkg::LEN_HIGH;
        end else if (tx_idx_reg == 5'h02) begin
            tx_byte = (status_reg == aih_pkg::STS_OK) ? aih_pkg::LEN_LOW_OK
                                                      : aih_pkg::LEN_LOW_ERR;
        end else if (tx_idx_reg == 5'h03) begin
            tx_byte = (status_reg == aih_pkg::STS_OK) ? aih_pkg::CMD_AREA_INFO
                                                      : aih_pkg::REPLY_ERR_CODE;
        end else if (tx_idx_reg == last_idx) begin
            tx_byte = aih_pkg::BYTE_END;
        end else if (tx_idx_reg == last_idx - 5'h01) begin
            tx_byte = 8'h00 - tx_sum_reg;
        end else begin
            // fields go out most significant byte first
            tx_byte = word_byte(payload_reg, tx_idx_reg - aih_pkg::PAYLOAD_IDX);
        end
    end

    // reply index and sum over length, code and payload
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            tx_idx_reg <= 5'h00;
            tx_sum_reg <= 8'h00;
        end else if (state_reg != aih_pkg::ST_SEND) begin
            tx_idx_reg <= 5'h00;
            tx_sum_reg <= 8'h00;
        end else if (push) begin
            tx_idx_reg <= tx_idx_reg + 5'h01;
            if (tx_idx_reg != 5'h00) begin
                tx_sum_reg <= tx_sum_reg + tx_byte;
            end
        end
    end

    // two-entry output buffer: head drives the port, spare absorbs a stall
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_tx             <= '0;
            spare_reg        <= '0;
            buf_in_ready_reg <= 1'b1;
        end else begin
            if (!o_tx.valid || i_tx_ready) begin
                if (spare_reg.valid) begin
                    o_tx      <= spare_reg;
                    spare_reg <= '0;
                end else begin
                    o_tx <= '{valid: push, data: tx_byte};
                end
            end else if (push) begin
                spare_reg <= '{valid: 1'b1, data: tx_byte};
            end
            buf_in_ready_reg <= !(o_tx.valid && !i_tx_ready &&
                                  (spare_reg.valid || push));
        end
    end

    // reported area count, last status and end-of-reply pulse
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_area_count  <= 8'(AREA_COUNT);
            o_last_status <= aih_pkg::STS_OK;
            o_reply_done  <= 1'b0;
        end else begin
            o_area_count <= 8'(AREA_COUNT);
            o_reply_done <= push && (tx_idx_reg == last_idx);
            if (push && tx_idx_reg == last_idx) begin
                o_last_status <= status_reg;
            end
        end
    end

endmodule : aih_handler

// file: verif/aih_handler_properties.sv
// checker for the area handler: reply framing, sums and fill bytes.
// assumes it is bound to aih_handler and sees only its ports.
`timescale 1ns/10ps
module aih_handler_chk #(
    parameter int AREA_COUNT = aih_pkg::AREA_COUNT
) (
    input  wire logic               i_clk_sys,
    input  wire logic               i_rst,
    input  wire aih_pkg::aih_byte_t o_tx,
    input  wire logic               i_tx_ready,
    input  wire logic               i_enc_write_done,
    input  wire logic [7:0]         o_area_count
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    logic       xfer;
    logic [4:0] last;
    logic [4:0] pos_reg;
    logic [7:0] lnl_reg;
    logic [7:0] sum_reg;
    logic       enc_reg;
    assign xfer = o_tx.valid && i_tx_ready;
    assign last = (lnl_reg == 8'h0a) ? 5'h0e : 5'h1e;
    // byte position inside the reply frame
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            pos_reg <= 5'h00;
        end else if (xfer) begin
            pos_reg <= (pos_reg == last) ? 5'h00 : pos_reg + 5'h01;
        end
    end
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            lnl_reg <= 8'h1a;
        end else if (xfer && pos_reg == 5'h02) begin
            lnl_reg <= o_tx.data;
        end
    end
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            sum_reg <= 8'h00;
        end else if (xfer) begin
            sum_reg <= (pos_reg == 5'h00) ? 8'h00 : sum_reg + o_tx.data;
        end
    end
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            enc_reg <= 1'b0;
        end else if (i_enc_write_done) begin
            enc_reg <= 1'b1;
        end
    end
    sequence s_take(logic [4:0] p);
        xfer && pos_reg == p;
    endsequence
    property p_tx_hold;
        o_tx.valid && !i_tx_ready |=> o_tx.valid && $stable(o_tx.data);
    endproperty
    property p_start;
        s_take(5'h00) |-> o_tx.data == 8'h81;
    endproperty
    property p_len_hi;
        s_take(5'h01) |-> o_tx.data == 8'h00;
    endproperty
    property p_len_lo;
        s_take(5'h02) |-> o_tx.data inside {8'h1a, 8'h0a};
    endproperty
    property p_code;
        s_take(5'h03) |-> o_tx.data == ((lnl_reg == 8'h1a) ? 8'h3b : 8'hbb);
    endproperty
    property p_accept;
        enc_reg ##0 s_take(5'h03) |-> o_tx.data == 8'hbb;
    endproperty
    property p_fill;
        xfer && lnl_reg == 8'h0a && pos_reg inside {[5'h05:5'h0c]} |-> o_tx.data == 8'hff;
    endproperty
    property p_sum;
        s_take(last - 5'h01) |-> 8'(sum_reg + o_tx.data) == 8'h00;
    endproperty
    property p_end;
        s_take(last) |-> o_tx.data == 8'h03;
    endproperty
    property p_count;
        o_area_count == 8'(AREA_COUNT);
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("stalled reply byte changed");
    a_start: assert property (p_start) else $error("bad reply start byte");
    a_len_hi: assert property (p_len_hi) else $error("bad reply length high");
    a_len_lo: assert property (p_len_lo) else $error("bad reply length low");
    a_code: assert property (p_code) else $error("reply code mismatches length");
    a_accept: assert property (p_accept) else $error("reply after encrypted write");
    a_fill: assert property (p_fill) else $error("error detail not all ones");
    a_sum: assert property (p_sum) else $error("reply frame check wrong");
    a_end: assert property (p_end) else $error("bad reply end byte");
    a_count: assert property (p_count) else $error("area count wrong");
endmodule : aih_handler_chk

bind aih_handler aih_handler_chk #(.AREA_COUNT(AREA_COUNT)) aih_handler_chk_inst (
    .i_clk_sys, .i_rst, .o_tx, .i_tx_ready, .i_enc_write_done, .o_area_count);

// file: verif/aih_host_model.sv
// host tool model: sends queued request bytes and collects reply bytes.
// assumes the handler on the same clock; i_slow stalls every other cycle.
`timescale 1ns/10ps
module aih_host_model (
    input  wire logic               i_clk_sys,
    input  wire logic               i_rst,
    input  wire logic               i_rx_ready,
    input  wire aih_pkg::aih_byte_t i_tx,
    input  wire logic               i_slow,
    output aih_pkg::aih_byte_t      o_rx,
    output logic                    o_tx_ready
);
    logic [7:0] send_q[$];
    logic [7:0] got_q[$];
    initial begin
        o_rx = '0;
        o_tx_ready = 1'b0;
    end
    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_rx <= '0;
            o_tx_ready <= 1'b0;
        end else begin
            // byte held until taken, line scrambled when nothing to send
            if (o_rx.valid && i_rx_ready) begin
                void'(send_q.pop_front());
            end
            if (send_q.size() > 0) begin
                o_rx <= {1'b1, send_q[0]};
            end else begin
                o_rx <= {1'b0, ~o_rx.data};
            end
            o_tx_ready <= i_slow ? ~o_tx_ready : 1'b1;
            if (i_tx.valid && o_tx_ready) begin
                got_q.push_back(i_tx.data);
            end
        end
    end
endmodule : aih_host_model

// file: verif/tb_top.sv
// testbench for the area handler: good, faulty and refused requests.
// assumes the host model and the bound checker beside the handler.
`timescale 1ns/10ps
module tb_top;
    logic               i_clk_sys  = 1'b0;
    logic               i_rst      = 1'b1;
    logic               enc_done   = 1'b0;
    logic               slow       = 1'b0;
    aih_pkg::aih_byte_t rx;
    aih_pkg::aih_byte_t tx;
    logic               rx_ready;
    logic               tx_ready;
    logic [7:0]         area_count;
    logic [7:0]         last_status;
    logic               reply_done;
    logic [7:0]         exp_q[$];
    int                 num_errors = 0;
    int                 n_compared = 0;
    int                 n_exp      = 0;
    int                 n_done     = 0;

    always #10 i_clk_sys = ~i_clk_sys;

    always @(posedge i_clk_sys) begin
        if (reply_done) n_done++;
    end

    aih_handler aih_handler_inst (
        .i_clk_sys        (i_clk_sys),
        .i_rst            (i_rst),
        .i_rx             (rx),
        .o_rx_ready       (rx_ready),
        .o_tx             (tx),
        .i_tx_ready       (tx_ready),
        .i_enc_write_done (enc_done),
        .o_area_count     (area_count),
        .o_last_status    (last_status),
        .o_reply_done     (reply_done)
    );
    aih_host_model aih_host_model_inst (
        .i_clk_sys  (i_clk_sys),
        .i_rst      (i_rst),
        .i_rx_ready (rx_ready),
        .i_tx       (tx),
        .i_slow     (slow),
        .o_rx       (rx),
        .o_tx_ready (tx_ready)
    );

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_sim

    // queue one request; bad flips bits of the frame check byte
    task automatic push_req(input logic [15:0] len, input logic [7:0] idx,
                            input logic [7:0] bad, input logic [7:0] endb);
        logic [7:0] s;
        logic [7:0] q[$];
        s = len[15:8] + len[7:0] + 8'h3b + idx;
        q = {8'h01, len[15:8], len[7:0], 8'h3b, idx};
        for (int i = 2; i < len; i++) q.push_back(8'h00);
        q.push_back((8'h00 - s) ^ bad);
        q.push_back(endb);
        @(negedge i_clk_sys);
        foreach (q[i]) aih_host_model_inst.send_q.push_back(q[i]);
    endtask : push_req

    task automatic exp_pkt(input logic [7:0] length_low, input logic [7:0] code,
                           input logic [199:0] body, input int n);
        logic [7:0] s;
        s = length_low + code;
        exp_q = {exp_q, 8'h81, 8'h00, length_low, code};
        for (int i = n - 1; i >= 0; i--) begin
            exp_q.push_back(body[i*8 +: 8]);
            s += body[i*8 +: 8];
        end
        exp_q = {exp_q, 8'h00 - s, 8'h03};
        n_exp++;
    endtask : exp_pkt

    // wait for all expected bytes, compare them and the final status
    task automatic get(input logic [7:0] sts);
        logic [7:0] got;
        int         n;
        for (n = 0; n < 5000 && aih_host_model_inst.got_q.size() < exp_q.size(); n++) begin
            @(negedge i_clk_sys);
        end
        chk("reply length", 8'(exp_q.size()), 8'(aih_host_model_inst.got_q.size()));
        foreach (exp_q[i]) begin
            got = (i < aih_host_model_inst.got_q.size()) ? aih_host_model_inst.got_q[i] : 8'hxx;
            chk("reply byte", exp_q[i], got);
        end
        for (n = 0; n < 50 && rx_ready !== 1'b1; n++) @(negedge i_clk_sys);
        chk("status", sts, last_status);
        chk("reply done", 8'(n_exp), 8'(n_done));
        exp_q.delete();
        aih_host_model_inst.got_q.delete();
    endtask : get

    task automatic err_case(input logic [15:0] len, input logic [7:0] idx,
                            input logic [7:0] bad, input logic [7:0] endb, input logic [7:0] sts);
        push_req(len, idx, bad, endb);
        exp_pkt(8'h0a, 8'hbb, {sts, 64'hffffffffffffffff}, 9);
        get(sts);
    endtask : err_case

    task automatic t_areas();
        @(posedge i_clk_sys);
        slow <= 1'b1;
        @(negedge i_clk_sys);
        aih_host_model_inst.send_q = {8'h55, 8'h03, 8'h81};
        for (int k = 0; k < 4; k++) begin
            push_req(16'h0002, 8'(k), 8'h00, 8'h03);
            exp_pkt(8'h1a, 8'h3b, aih_pkg::AREA_TABLE[k], 25);
        end
        get(aih_pkg::STS_OK);
        @(posedge i_clk_sys);
        slow <= 1'b0;
        $display("test areas done");
    endtask : t_areas

    task automatic t_errors();
        err_case(16'h0002, 8'h00, 8'h00, 8'h55, aih_pkg::STS_PACKET);
        err_case(16'h0002, 8'h00, 8'h01, 8'h03, aih_pkg::STS_CHECKSUM);
        err_case(16'h0002, 8'h00, 8'h01, 8'h55, aih_pkg::STS_PACKET);
        err_case(16'h0003, 8'h00, 8'h00, 8'h03, aih_pkg::STS_PACKET);
        err_case(16'h0003, 8'h00, 8'h01, 8'h03, aih_pkg::STS_CHECKSUM);
        err_case(16'h0401, 8'h00, 8'h00, 8'h03, aih_pkg::STS_PACKET);
        err_case(16'h0002, 8'h04, 8'h00, 8'h03, aih_pkg::STS_PARAM);
        err_case(16'h0002, 8'hff, 8'h00, 8'h03, aih_pkg::STS_PARAM);
        aih_host_model_inst.send_q = {8'h01, 8'h00, 8'h00, 8'h00, 8'h03};
        push_req(16'h0002, 8'h01, 8'h00, 8'h03);
        exp_pkt(8'h1a, 8'h3b, aih_pkg::AREA_TABLE[1], 25);
        get(aih_pkg::STS_OK);
        $display("test errors done");
    endtask : t_errors

    task automatic t_accept();
        @(posedge i_clk_sys);
        enc_done <= 1'b1;
        @(posedge i_clk_sys);
        enc_done <= 1'b0;
        err_case(16'h0002, 8'h04, 8'h00, 8'h03, aih_pkg::STS_ACCEPT);
        err_case(16'h0002, 8'h00, 8'h00, 8'h03, aih_pkg::STS_ACCEPT);
        err_case(16'h0002, 8'h00, 8'h01, 8'h03, aih_pkg::STS_CHECKSUM);
        @(posedge i_clk_sys);
        i_rst <= 1'b1;
        repeat (20) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        repeat (2) @(posedge i_clk_sys);
        chk("area count", 8'(aih_pkg::AREA_COUNT), area_count);
        push_req(16'h0002, 8'h02, 8'h00, 8'h03);
        exp_pkt(8'h1a, 8'h3b, aih_pkg::AREA_TABLE[2], 25);
        get(aih_pkg::STS_OK);
        $display("test accept done");
    endtask : t_accept

    initial begin
        repeat (20000) @(posedge i_clk_sys);
        num_errors++;
        $display("Error watchdog expected finish seen hang");
        end_sim();
    end

    initial begin
        repeat (20) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        repeat (2) @(posedge i_clk_sys);
        chk("area count", 8'(aih_pkg::AREA_COUNT), area_count);
        t_areas();
        t_errors();
        t_accept();
        end_sim();
    end
endmodule : tb_top
